/* File: ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ram_model;
  // Nibble store at {file, word}; swaps write the old accumulator back here.
  logic [3:0] mem [64];
endmodule
`default_nettype wire

/* File: ram_pointer_defs.sv */
// Contract
// - Expansion-to-pair: expansion high nibble to second register, low nibble to accumulator.
// - Digit-select load copies accumulator low three bits; accumulator stays unchanged.
// - Pointer load writes 2-bit file selector and 4-bit word pointer immediates.
// - Directly following pointer loads after the first are treated as skipped.
// - Increment word pointer; skip next instruction when it wraps to zero.
// - Decrement word pointer; skip next instruction when it wraps to fifteen.
// - Load memory nibble into accumulator, then file selector XOR immediate.
// - Swap accumulator with memory nibble, then file selector XOR immediate.
// - Swap, file selector update, decrement word pointer, skip on fifteen.
// - Swap, file selector update, increment word pointer, skip on zero.
// - Register-to-register transfers never skip the next instruction.
// - Pair-to-expansion: second register to upper bits, accumulator to lower bits.
package ram_pointer_pkg;
  // ---------------------------------------------------------------
  // Opcodes and decode masks
  // ---------------------------------------------------------------
  localparam logic [8:0] OP_TAB_TO_ACC = 9'h01E;
  localparam logic [8:0] OP_ACC_TO_B = 9'h00E;
  localparam logic [8:0] OP_WORD_TO_ACC = 9'h01F;
  localparam logic [8:0] OP_ACC_TO_WORD = 9'h00C;
  localparam logic [8:0] OP_PAIR_TO_EXP = 9'h01A;
  localparam logic [8:0] OP_EXP_TO_PAIR = 9'h02A;
  localparam logic [8:0] OP_ACC_TO_DIGIT = 9'h029;
  localparam logic [8:0] OP_INC_WORD = 9'h013;
  localparam logic [8:0] OP_DEC_WORD = 9'h017;
  localparam logic [8:0] MASK_PTR_LOAD = 9'h1C0;
  localparam logic [8:0] OP_PTR_LOAD = 9'h0C0;
  localparam logic [8:0] MASK_J = 9'h1FC;
  localparam logic [8:0] OP_LOAD_MEM = 9'h064;
  localparam logic [8:0] OP_SWAP = 9'h060;
  localparam logic [8:0] OP_SWAP_DEC = 9'h06C;
  localparam logic [8:0] OP_SWAP_INC = 9'h068;
  // ---------------------------------------------------------------
  // Field positions, widths and word pointer wrap values
  // ---------------------------------------------------------------
  localparam int IMM_X_LSB = 4;
  localparam int IMM_X_HI = IMM_X_LSB + 1;
  localparam int RAM_AW = 6;
  localparam logic [3:0] WORD_WRAP_UP = 4'h0;
  localparam logic [3:0] WORD_WRAP_DOWN = 4'hF;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] RST_EXP = 8'h00;
  localparam logic [2:0] RST_DIGIT = 3'h0;
  localparam logic [1:0] RST_FILE = 2'h0;
endpackage

`timescale 1ns/1ps
`default_nettype none
module nibble_ram (
  input wire logic mclk_i,
  input wire logic wr_i,
  input wire logic [ram_pointer_pkg::RAM_AW-1:0] addr_i,
  input wire logic [3:0] wdata_i,
  output logic [3:0] rdata_o
);
  logic [3:0] mem [0:(1<<ram_pointer_pkg::RAM_AW)-1];

  // Read is combinational so a swap completes in the cycle it is issued.
  assign rdata_o = mem[addr_i];

  always_ff @(posedge mclk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

/* File: ram_pointer_transfer_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module ram_pointer_transfer_exec (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [8:0] instr_i,
  input wire logic instr_skip_i,
  input wire logic acc_wr_i,
  input wire logic [3:0] acc_wr_data_i,
  input wire logic b_wr_i,
  input wire logic [3:0] b_wr_data_i,
  output logic [3:0] acc_o,
  output logic [3:0] breg_o,
  output logic [7:0] expansion_o,
  output logic [2:0] digit_select_o,
  output logic [1:0] file_sel_o,
  output logic [3:0] word_ptr_o,
  output logic skip_next_o,
  output logic ptr_load_skipped_o,
  output logic done_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [3:0] acc_reg, acc_next;
  logic [3:0] b_reg, b_next;
  logic [7:0] exp_reg, exp_next;
  logic [2:0] digit_reg, digit_next;
  logic [1:0] file_reg, file_next;
  logic [3:0] word_reg, word_next;
  // The three pulse registers below stand for exactly one cycle.
  logic skip_reg, skip_next;
  logic lxy_skip_reg, lxy_skip_next;
  logic done_reg, done_next;
  logic last_lxy_reg, last_lxy_next;

  logic [3:0] ram_rdata;
  logic ram_wr;
  logic [3:0] ram_wdata;
  logic [ram_pointer_pkg::RAM_AW-1:0] ram_addr;

  logic is_lxy, is_load_mem, is_swap, is_swap_dec, is_swap_inc;
  logic [1:0] imm_j;
  logic [3:0] word_inc, word_dec;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // The group is decoded from fixed bit patterns; the two-bit file
  // toggle rides in the lowest bits of every memory transfer.
  assign imm_j = instr_i[1:0];
  assign word_inc = word_reg + 4'h1;
  assign word_dec = word_reg - 4'h1;
  assign is_lxy = (instr_i & ram_pointer_pkg::MASK_PTR_LOAD) == ram_pointer_pkg::OP_PTR_LOAD;
  assign is_load_mem = (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_LOAD_MEM;
  assign is_swap = (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_SWAP;
  assign is_swap_dec = (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_SWAP_DEC;
  assign is_swap_inc = (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_SWAP_INC;

  // The data pointer is the file selector over the word pointer.
  assign ram_addr = {file_reg, word_reg};

  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  // The store is not cleared by reset, so code must write a nibble before it
  // reads it; clearing sixty-four entries would cost a long reset sequence.
  nibble_ram u_ram (
    .mclk_i(mclk_i),
    .wr_i(ram_wr),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  // Every instruction here finishes in the cycle it is presented and no
  // carry is touched, since this block holds no carry at all.
  always_comb begin
    acc_next = acc_reg;
    b_next = b_reg;
    exp_next = exp_reg;
    digit_next = digit_reg;
    file_next = file_reg;
    word_next = word_reg;
    skip_next = 1'b0;
    lxy_skip_next = 1'b0;
    done_next = 1'b0;
    last_lxy_next = last_lxy_reg;
    ram_wr = 1'b0;
    ram_wdata = acc_reg;
    // Writes from other units of the core come first; an instruction in
    // the same cycle overrides them.
    if (acc_wr_i) begin
      acc_next = acc_wr_data_i;
    end
    if (b_wr_i) begin
      b_next = b_wr_data_i;
    end
    if (instr_valid_i) begin
      // Any slot of this group, skipped or not, reports completion.
      done_next = 1'b1;
      // A chain of pointer loads counts even through skipped slots, so a
      // table of loads can be entered at any entry and only that one acts.
      last_lxy_next = is_lxy;
      if (instr_skip_i) begin
        done_next = 1'b1;
      end else if (is_lxy && last_lxy_reg) begin
        lxy_skip_next = 1'b1;
      end else if (is_lxy) begin
        file_next = instr_i[ram_pointer_pkg::IMM_X_HI:ram_pointer_pkg::IMM_X_LSB];
        word_next = instr_i[3:0];
      end else if (is_load_mem) begin
        acc_next = ram_rdata;
        file_next = file_reg ^ imm_j;
      end else if (is_swap || is_swap_dec || is_swap_inc) begin
        // The old accumulator goes to the same address that is read, because
        // the pointer only moves at the clock edge that ends this cycle.
        acc_next = ram_rdata;
        ram_wr = 1'b1;
        ram_wdata = acc_reg;
        file_next = file_reg ^ imm_j;
        // Only the skip request is made here; the core squashes the slot.
        if (is_swap_dec) begin
          word_next = word_dec;
          skip_next = (word_dec == ram_pointer_pkg::WORD_WRAP_DOWN);
        end
        if (is_swap_inc) begin
          word_next = word_inc;
          skip_next = (word_inc == ram_pointer_pkg::WORD_WRAP_UP);
        end
      end else begin
        // Transfers below leave skip_next low, except OP_INC_WORD and OP_DEC_WORD, which request a skip on wrap.
        case (instr_i)
          ram_pointer_pkg::OP_EXP_TO_PAIR: begin
            // The expansion register is only ever split or built as a whole byte.
            b_next = exp_reg[7:4];
            acc_next = exp_reg[3:0];
          end
          ram_pointer_pkg::OP_PAIR_TO_EXP: begin
            exp_next = {b_reg, acc_reg};
          end
          ram_pointer_pkg::OP_ACC_TO_DIGIT: begin
            digit_next = acc_reg[2:0];
          end
          ram_pointer_pkg::OP_TAB_TO_ACC: begin
            acc_next = b_reg;
          end
          ram_pointer_pkg::OP_ACC_TO_B: begin
            b_next = acc_reg;
          end
          ram_pointer_pkg::OP_WORD_TO_ACC: begin
            acc_next = word_reg;
          end
          ram_pointer_pkg::OP_ACC_TO_WORD: begin
            word_next = acc_reg;
          end
          ram_pointer_pkg::OP_INC_WORD: begin
            // The wrap test looks at the new value, which is what the core skips on.
            word_next = word_inc;
            skip_next = (word_inc == ram_pointer_pkg::WORD_WRAP_UP);
          end
          ram_pointer_pkg::OP_DEC_WORD: begin
            word_next = word_dec;
            skip_next = (word_dec == ram_pointer_pkg::WORD_WRAP_DOWN);
          end
          default: begin
            // Opcodes of other groups leave this state untouched.
            done_next = 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset is synchronous; the store itself keeps its contents.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      acc_reg <= ram_pointer_pkg::RST_NIBBLE;
      b_reg <= ram_pointer_pkg::RST_NIBBLE;
      exp_reg <= ram_pointer_pkg::RST_EXP;
      digit_reg <= ram_pointer_pkg::RST_DIGIT;
      file_reg <= ram_pointer_pkg::RST_FILE;
      word_reg <= ram_pointer_pkg::RST_NIBBLE;
      skip_reg <= 1'b0;
      lxy_skip_reg <= 1'b0;
      done_reg <= 1'b0;
      last_lxy_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      exp_reg <= exp_next;
      digit_reg <= digit_next;
      file_reg <= file_next;
      word_reg <= word_next;
      skip_reg <= skip_next;
      lxy_skip_reg <= lxy_skip_next;
      done_reg <= done_next;
      last_lxy_reg <= last_lxy_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a register, so the core never sees decode glitches.
  assign acc_o = acc_reg;
  assign breg_o = b_reg;
  assign expansion_o = exp_reg;
  assign digit_select_o = digit_reg;
  assign file_sel_o = file_reg;
  assign word_ptr_o = word_reg;
  assign skip_next_o = skip_reg;
  assign ptr_load_skipped_o = lxy_skip_reg;
  assign done_o = done_reg;
endmodule
`default_nettype wire

/* File: ram_pointer_transfer_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ram_pointer_transfer_exec_properties (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [8:0] instr_i,
  input wire logic instr_skip_i,
  input wire logic acc_wr_i,
  input wire logic [3:0] acc_o,
  input wire logic [3:0] breg_o,
  input wire logic [7:0] expansion_o,
  input wire logic [2:0] digit_select_o,
  input wire logic [1:0] file_sel_o,
  input wire logic [3:0] word_ptr_o,
  input wire logic skip_next_o,
  input wire logic ptr_load_skipped_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire logic v = instr_valid_i && !instr_skip_i;
  wire logic pl = (instr_i & ram_pointer_pkg::MASK_PTR_LOAD) == ram_pointer_pkg::OP_PTR_LOAD;
  logic chain_reg;
  // Any valid slot counts for the chain, skipped ones included.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) chain_reg <= 1'b0;
    else if (instr_valid_i) chain_reg <= pl;
  end
  property p_split;
    v && instr_i == ram_pointer_pkg::OP_EXP_TO_PAIR |=>
      {breg_o, acc_o} == $past(expansion_o) && !skip_next_o;
  endproperty
  a_split: assert property (p_split) else $error("split mismatch");
  property p_pair;
    v && instr_i == ram_pointer_pkg::OP_PAIR_TO_EXP |=>
      expansion_o == {$past(breg_o), $past(acc_o)};
  endproperty
  a_pair: assert property (p_pair) else $error("pair mismatch");
  property p_digit;
    v && !acc_wr_i && instr_i == ram_pointer_pkg::OP_ACC_TO_DIGIT |=>
      digit_select_o == 3'($past(acc_o)) && $stable(acc_o);
  endproperty
  a_digit: assert property (p_digit) else $error("digit mismatch");
  property p_ptr;
    v && pl && !chain_reg |=>
      {file_sel_o, word_ptr_o} == 6'($past(instr_i)) && !ptr_load_skipped_o;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load mismatch");
  property p_chain;
    v && pl && chain_reg |=> ptr_load_skipped_o && $stable(word_ptr_o) && $stable(file_sel_o);
  endproperty
  a_chain: assert property (p_chain) else $error("chain follower executed");
  property p_inc;
    v && instr_i == ram_pointer_pkg::OP_INC_WORD |=>
      word_ptr_o == $past(word_ptr_o) + 4'h1 && skip_next_o == (word_ptr_o == 4'h0);
  endproperty
  a_inc: assert property (p_inc) else $error("increment mismatch");
  property p_dec;
    v && instr_i == ram_pointer_pkg::OP_DEC_WORD |=>
      word_ptr_o == $past(word_ptr_o) - 4'h1 && skip_next_o == (word_ptr_o == 4'hF);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement mismatch");
  property p_xor;
    v && (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_LOAD_MEM |=>
      file_sel_o == ($past(file_sel_o) ^ 2'($past(instr_i))) && !skip_next_o;
  endproperty
  a_xor: assert property (p_xor) else $error("file select mismatch");
  property p_swap_dec;
    v && (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_SWAP_DEC |=>
      word_ptr_o == $past(word_ptr_o) - 4'h1 && skip_next_o == (word_ptr_o == 4'hF) &&
      file_sel_o == ($past(file_sel_o) ^ 2'($past(instr_i)));
  endproperty
  a_swap_dec: assert property (p_swap_dec) else $error("swap then decrement mismatch");
  property p_swap_inc;
    v && (instr_i & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_SWAP_INC |=>
      word_ptr_o == $past(word_ptr_o) + 4'h1 && skip_next_o == (word_ptr_o == 4'h0) &&
      file_sel_o == ($past(file_sel_o) ^ 2'($past(instr_i)));
  endproperty
  a_swap_inc: assert property (p_swap_inc) else $error("swap then increment mismatch");
endmodule
bind ram_pointer_transfer_exec ram_pointer_transfer_exec_properties u_props (.*);
`default_nettype wire

/* File: ram_pointer_transfer_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ram_pointer_transfer_exec_tb;
  logic mclk_i = 0, resetn_i = 0, v = 0, sk = 0, aw = 0, bw = 0, es = 0, ep = 0, en = 0, ch = 0;
  logic [8:0] ins = 9'h000, i;
  logic [3:0] ad = 4'h0, bd = 4'h0, acc_o, breg_o, word_ptr_o, ea = 0, eb = 0, ey = 0;
  logic [7:0] expansion_o, ee = 0;
  logic [2:0] digit_select_o, ed = 0;
  logic [1:0] file_sel_o, ex = 0;
  logic skip_next_o, ptr_load_skipped_o, done_o;
  int n_fail = 0, checked = 0, r;
  logic [8:0] ops [14] = '{ram_pointer_pkg::OP_TAB_TO_ACC, ram_pointer_pkg::OP_ACC_TO_B,
    ram_pointer_pkg::OP_WORD_TO_ACC, ram_pointer_pkg::OP_ACC_TO_WORD,
    ram_pointer_pkg::OP_PAIR_TO_EXP, ram_pointer_pkg::OP_EXP_TO_PAIR,
    ram_pointer_pkg::OP_ACC_TO_DIGIT, ram_pointer_pkg::OP_INC_WORD, ram_pointer_pkg::OP_DEC_WORD,
    ram_pointer_pkg::OP_PTR_LOAD, ram_pointer_pkg::OP_LOAD_MEM, ram_pointer_pkg::OP_SWAP,
    ram_pointer_pkg::OP_SWAP_DEC, ram_pointer_pkg::OP_SWAP_INC};
  always #2 mclk_i = ~mclk_i;
  ram_model u_ram ();
  ram_pointer_transfer_exec u_dut (.mclk_i, .resetn_i, .instr_valid_i(v), .instr_i(ins),
    .instr_skip_i(sk), .acc_wr_i(aw), .acc_wr_data_i(ad), .b_wr_i(bw), .b_wr_data_i(bd),
    .acc_o, .breg_o, .expansion_o, .digit_select_o, .file_sel_o, .word_ptr_o, .skip_next_o,
    .ptr_load_skipped_o, .done_o);
  task end_sim;
    $display("n_fail=%0d checked=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp(input logic ok, input string m);
    checked++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // ----------------------------------------------------------------
  // One slot: drive, check the previous slot, then advance the model.
  // ----------------------------------------------------------------
  task step(input logic [8:0] op, input logic vv, s, a, b);
    logic [3:0] oa, ob, m, da, db;
    logic pl;
    da = $urandom;
    db = $urandom;
    @(posedge mclk_i);
    {v, ins, sk, aw, bw, ad, bd} <= {vv, op, s, a, b, da, db};
    @(negedge mclk_i);
    cmp(acc_o === ea, "acc");
    cmp(breg_o === eb && expansion_o === ee, "b or expansion");
    cmp(digit_select_o === ed, "digit");
    cmp(file_sel_o === ex && word_ptr_o === ey, "pointer");
    cmp(skip_next_o === es, "skip");
    cmp(ptr_load_skipped_o === ep, "chain");
    cmp(done_o === en, "done");
    {oa, ob, es, ep, en} = {ea, eb, 3'b000};
    if (a) ea = da;
    if (b) eb = db;
    if (vv) begin
      pl = (op & ram_pointer_pkg::MASK_PTR_LOAD) == ram_pointer_pkg::OP_PTR_LOAD;
      m = u_ram.mem[{ex, ey}];
      r = (op & ram_pointer_pkg::MASK_J) == ram_pointer_pkg::OP_LOAD_MEM ? 10 : 0;
      for (int k = 0; k < 14; k++) if (r == 0 && op == ops[k]) r = k + 1;
      for (int k = 11; k < 14; k++) if ((op & ram_pointer_pkg::MASK_J) == ops[k]) r = k;
      en = s || r > 0 || pl;
      if (s) en = 1;
      else if (pl && ch) {ep, en} = 2'b11;
      else if (pl) {ex, ey} = op[5:0];
      else case (r)
        1: ea = ob;
        2: eb = oa;
        3: ea = ey;
        4: ey = oa;
        5: ee = {ob, oa};
        6: {eb, ea} = ee;
        7: ed = oa[2:0];
        8: {ey, es} = {ey + 4'h1, ey == 4'hF};
        9: {ey, es} = {ey - 4'h1, ey == 4'h0};
        10: {ea, ex} = {m, ex ^ op[1:0]};
        11, 12, 13: begin
          u_ram.mem[{ex, ey}] = oa;
          {ea, ex} = {m, ex ^ op[1:0]};
          if (r == 12) {ey, es} = {ey - 4'h1, ey == 4'h0};
          if (r == 13) {ey, es} = {ey + 4'h1, ey == 4'hF};
        end
        default: en = 0;
      endcase
      ch = pl;
    end
  endtask
  initial begin
    void'($urandom(32'h0135_b2c8));
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      step(ram_pointer_pkg::OP_PTR_LOAD | 9'(k), 1, 0, 1, 0);
      step(ram_pointer_pkg::OP_SWAP, 1, 0, 0, 0);
    end
    $display("test fill done");
    step(ram_pointer_pkg::OP_PTR_LOAD | 9'h00F, 1, 0, 1, 0);
    step(ram_pointer_pkg::OP_INC_WORD, 1, 0, 0, 0);
    step(ram_pointer_pkg::OP_PTR_LOAD | 9'h030, 1, 0, 0, 0);
    step(9'h000, 0, 0, 0, 0);
    step(ram_pointer_pkg::OP_PTR_LOAD | 9'h021, 1, 0, 0, 0);
    step(ram_pointer_pkg::OP_PTR_LOAD | 9'h012, 1, 1, 0, 0);
    step(ram_pointer_pkg::OP_PTR_LOAD | 9'h013, 1, 0, 0, 0);
    step(ram_pointer_pkg::OP_DEC_WORD, 1, 0, 0, 0);
    $display("test corners done");
    repeat (4000) begin
      r = $urandom_range(13);
      i = ops[r];
      if (r >= 10) i[1:0] = 2'($urandom);
      if (r == 9) i[5:0] = 6'($urandom);
      if ($urandom_range(15) == 0) i = 9'($urandom);
      step(i, $urandom_range(7) != 0, $urandom_range(15) == 0, $urandom_range(3) == 0,
        $urandom_range(3) == 0);
    end
    $display("test random done");
    end_sim();
  end
endmodule
`default_nettype wire
